/* File: chan_regs.sv */
// One channel's register bank and serial line idle control.
// Assumes write strobes arrive as one-cycle pulses on clk.
`timescale 1ns/10ps
`include "host_port_defines.svh"
module chan_regs #(
   parameter int DW = `HP_DATA_W,
   parameter int AW = `HP_ADDR_W
) (
   input  wire logic          clk,       // System clock
   input  wire logic          rst,       // Sync reset, high
   input  wire logic          wr_en,     // Write pulse
   input  wire logic [AW-1:0] addr,      // Register index
   input  wire logic [DW-1:0] wdata,     // Write data
   input  wire logic          tx_data,   // Serial bit from transmitter
   input  wire logic          tx_busy,   // Transmitter sending
   output logic      [DW-1:0] rdata,     // Read data
   output logic               ir_mode,   // Infrared mode
   output logic               serial_out // Transmit pin
);
   logic [DW-1:0] regs_ff [2**AW];

   // ************************************************
   // Register bank
   // ************************************************
   always_ff @(posedge clk) begin
      if (rst) begin
         for (int i = 0; i < 2**AW; i++) begin
            regs_ff[i] <= `HP_RESET_BYTE;
         end
      end else if (wr_en) begin
         regs_ff[addr] <= wdata;
      end
   end

   assign rdata   = regs_ff[addr];
   assign ir_mode = regs_ff[`HP_MCR_ADDR][`HP_MCR_IR_BIT];

   // ************************************************
   // Transmit pin idle level
   // ************************************************
   logic serial_out_ff;
   always_ff @(posedge clk) begin
      if (rst) begin
         serial_out_ff <= 1'b1;
      end else if (tx_busy) begin
         serial_out_ff <= ir_mode ? ~tx_data : tx_data;
      end else begin
         serial_out_ff <= ~ir_mode;
      end
   end
   assign serial_out = serial_out_ff;

   chk_idle_level: assert property (@(posedge clk) disable iff (rst)
      !$past(tx_busy) && !$past(rst) |-> serial_out == ~$past(ir_mode))
      else $error("Transmit idle level wrong");
endmodule

/* File: host_bus_port.sv */
// Top of the dual channel parallel host bus port.
// Assumes bus pins are synchronous to clk; data pins tri-stated outside.
// Overview of operation
// - A read strobe fall reads the addressed register onto the data bus.
// - A write strobe rise stores the bus byte into the addressed register.
// - Chip select low enables access, steered by the channel pick.
// - Channel pick low selects channel B, high selects channel A.
// - Alternate function bit 0 makes one write update both channels.
// - Each channel drives its interrupt high while requesting service.
// - Each channel drives a low-active ready showing transmit space.
// - Modem control bit 6 switches a channel to the infrared path.
// - In standard mode transmit idles high, including reset.
// - In infrared mode transmit rests low when idle.
// - Three address lines select a register; data is eight bits wide.
`timescale 1ns/10ps
`include "host_port_defines.svh"
module host_bus_port #(
   parameter int DW = `HP_DATA_W,
   parameter int AW = `HP_ADDR_W
) (
   input  wire logic                   clk,         // System clock
   input  wire logic                   rst,         // Sync reset, high
   input  wire host_port_pkg::bus_in_t bus_in,      // Host bus pins
   output logic [DW-1:0]               data_out,    // Data bus drive
   output logic                        data_oe,     // Data bus enable
   input  wire logic [1:0]             svc_req,     // Channel service req
   input  wire logic [1:0]             tx_space,    // Channel can accept
   input  wire logic [1:0]             tx_data,     // Serial bits
   input  wire logic [1:0]             tx_busy,     // Transmitters busy
   output logic                        irq_chan_a,  // Interrupt A
   output logic                        irq_chan_b,  // Interrupt B
   output logic                        tx_space_avail_a_n, // Ready A
   output logic                        tx_space_avail_b_n, // Ready B
   output logic                        serial_out_a, // Transmit A
   output logic                        serial_out_b, // Transmit B
   output logic [1:0]                  ir_mode      // Infrared mode
);
   host_port_pkg::cyc_state_t state_ff;
   logic            rd_n_ff;
   logic            wr_n_ff;
   logic [1:0]      wr_pulse;
   logic [DW-1:0]   rdata [2];
   logic [DW-1:0]   data_out_ff;
   logic            data_oe_ff;
   logic            both_ff;
   logic [1:0]      irq_ff;
   logic [1:0]      rdy_n_ff;
   logic [1:0]      ser;

   // Index 1 is channel A, index 0 channel B
   function automatic logic [1:0] chan_mask(input logic pick,
                                            input logic both);
      if (both) begin
         chan_mask = 2'h3;
      end else if (pick == `HP_SEL_CHAN_A) begin
         chan_mask = 2'h2;
      end else begin
         chan_mask = 2'h1;
      end
   endfunction

   wire sel      = ~bus_in.cs_n;
   wire rd_fall  = sel & rd_n_ff & ~bus_in.rd_n;
   wire wr_fall  = sel & wr_n_ff & ~bus_in.wr_n;
   wire wr_rise  = sel & ~wr_n_ff & bus_in.wr_n;

   // ************************************************
   // Strobe edge detection
   // ************************************************
   always_ff @(posedge clk) begin
      if (rst) begin
         rd_n_ff <= 1'b1;
         wr_n_ff <= 1'b1;
      end else begin
         rd_n_ff <= bus_in.rd_n;
         wr_n_ff <= bus_in.wr_n;
      end
   end

   // ************************************************
   // Cycle state
   // ************************************************
   always_ff @(posedge clk) begin
      if (rst) begin
         state_ff <= host_port_pkg::ST_IDLE;
      end else begin
         case (state_ff)
            host_port_pkg::ST_IDLE: begin
               if (rd_fall) begin
                  state_ff <= host_port_pkg::ST_READ;
               end else if (wr_fall) begin
                  state_ff <= host_port_pkg::ST_WRITE;
               end
            end
            host_port_pkg::ST_READ: begin
               if (bus_in.rd_n || bus_in.cs_n) begin
                  state_ff <= host_port_pkg::ST_IDLE;
               end
            end
            host_port_pkg::ST_WRITE: begin
               if (bus_in.wr_n || bus_in.cs_n) begin
                  state_ff <= host_port_pkg::ST_IDLE;
               end
            end
            default: state_ff <= host_port_pkg::ST_IDLE;
         endcase
      end
   end

   // Write lands on strobe rise, one or both channels
   assign wr_pulse = (wr_rise && state_ff == host_port_pkg::ST_WRITE)
                     ? chan_mask(bus_in.pick, both_ff)
                     : 2'h0;

   // ************************************************
   // Broadcast bit shadow of the alternate function reg
   // ************************************************
   always_ff @(posedge clk) begin
      if (rst) begin
         both_ff <= 1'b0;
      end else if (wr_pulse != 2'h0 && bus_in.addr == `HP_AFR_ADDR) begin
         both_ff <= bus_in.din[`HP_AFR_BOTH_BIT];
      end
   end

   // ************************************************
   // Channel banks
   // ************************************************
   for (genvar c = 0; c < 2; c++) begin : g_chan
      chan_regs #(.DW(DW), .AW(AW)) u_chan (
         .clk        (clk),
         .rst        (rst),
         .wr_en      (wr_pulse[c]),
         .addr       (bus_in.addr),
         .wdata      (bus_in.din),
         .tx_data    (tx_data[c]),
         .tx_busy    (tx_busy[c]),
         .rdata      (rdata[c]),
         .ir_mode    (ir_mode[c]),
         .serial_out (ser[c])
      );
   end

   // ************************************************
   // Read data drive
   // ************************************************
   always_ff @(posedge clk) begin
      if (rst) begin
         data_out_ff <= `HP_RESET_BYTE;
         data_oe_ff  <= 1'b0;
      end else if (bus_in.cs_n || bus_in.rd_n) begin
         data_oe_ff  <= 1'b0;
      end else if (rd_fall) begin
         data_out_ff <= (bus_in.pick == `HP_SEL_CHAN_A)
                        ? rdata[1] : rdata[0];
         data_oe_ff  <= 1'b1;
      end
   end

   // ************************************************
   // Status outputs
   // ************************************************
   always_ff @(posedge clk) begin
      if (rst) begin
         irq_ff   <= 2'h0;
         rdy_n_ff <= 2'h3;
      end else begin
         irq_ff   <= svc_req;
         rdy_n_ff <= ~tx_space;
      end
   end

   assign data_out           = data_out_ff;
   assign data_oe            = data_oe_ff;
   assign irq_chan_a         = irq_ff[1];
   assign irq_chan_b         = irq_ff[0];
   assign tx_space_avail_a_n = rdy_n_ff[1];
   assign tx_space_avail_b_n = rdy_n_ff[0];
   assign serial_out_a       = ser[1];
   assign serial_out_b       = ser[0];

   // ************************************************
   // Checks
   // ************************************************
   sequence s_read_start;
      rd_fall;
   endsequence

   chk_read_drive: assert property (@(posedge clk) disable iff (rst)
      s_read_start ##1 (!bus_in.rd_n && !bus_in.cs_n) |-> data_oe)
      else $error("Read data not driven");
   chk_deselect_hiz: assert property (@(posedge clk) disable iff (rst)
      $past(bus_in.cs_n) && !$past(rst) |-> !data_oe)
      else $error("Bus driven while deselected");
   chk_chan_a_write: assert property (@(posedge clk) disable iff (rst)
      wr_pulse[1] |-> (bus_in.pick || both_ff) && !bus_in.cs_n)
      else $error("Channel A write misrouted");
   chk_chan_b_write: assert property (@(posedge clk) disable iff (rst)
      wr_pulse[0] |-> (!bus_in.pick || both_ff))
      else $error("Channel B write misrouted");
   chk_broadcast_write: assert property (@(posedge clk) disable iff (rst)
      both_ff && wr_rise && state_ff == host_port_pkg::ST_WRITE
      |-> wr_pulse == 2'h3)
      else $error("Broadcast write missed a channel");
   chk_write_on_rise: assert property (@(posedge clk) disable iff (rst)
      wr_pulse != 2'h0 |-> !$past(bus_in.wr_n) && bus_in.wr_n)
      else $error("Write outside strobe rise");
   chk_irq_follow: assert property (@(posedge clk) disable iff (rst)
      !$past(rst) |-> irq_chan_a == $past(svc_req[1]))
      else $error("Interrupt A wrong");
   chk_ready_follow: assert property (@(posedge clk) disable iff (rst)
      !$past(rst) |-> tx_space_avail_b_n == !$past(tx_space[0]))
      else $error("Ready B wrong");
   chk_irq_b_follow: assert property (@(posedge clk) disable iff (rst)
      !$past(rst) |-> irq_chan_b == $past(svc_req[0]))
      else $error("Interrupt B wrong");
   chk_ready_a_follow: assert property (@(posedge clk) disable iff (rst)
      !$past(rst) |-> tx_space_avail_a_n == !$past(tx_space[1]))
      else $error("Ready A wrong");
   chk_read_hold: assert property (@(posedge clk) disable iff (rst)
      data_oe && !bus_in.rd_n && !bus_in.cs_n |=> data_oe)
      else $error("Read data dropped early");
endmodule

/* File: host_model.sv */
// Host processor model driving the parallel bus port.
// Assumes the testbench calls its tasks just after a rising edge.
`timescale 1ns/10ps
module host_model (
   input  wire logic                  clk,      // System clock
   input  wire logic [7:0]            data_out, // Port data drive
   input  wire logic                  data_oe,  // Port drive enable
   output host_port_pkg::bus_in_t     bus_in    // Bus pins to port
);
   logic       cs_n;  // Chip select
   logic       pick;  // Channel pick
   logic       rd_n;  // Read strobe
   logic       wr_n;  // Write strobe
   logic [2:0] addr;  // Register index
   logic       drv;   // Host drives data
   logic [7:0] hd;    // Host data
   logic [7:0] last;  // Bus value last edge
   logic [7:0] bus;   // Resolved data bus
   // Released bus shows a changing pattern
   assign bus = data_oe ? data_out : (drv ? hd : ~last);
   assign bus_in = '{cs_n, pick, rd_n, wr_n, addr, bus};
   always @(posedge clk)
      last <= bus;
   initial begin
      {cs_n, rd_n, wr_n, drv, pick, addr, hd, last} = {4'he, 20'h00000};
   end
   // **************************
   // Bus cycles
   // **************************
   task automatic wr(input logic c, input logic p, input logic [2:0] a,
                     input logic [7:0] d);
      {cs_n, pick, addr, hd, drv, wr_n} = {c, p, a, d, 2'b10};
      repeat (2) @(posedge clk);
      #1 wr_n = 1'b1;
      @(posedge clk);
      #1 {cs_n, drv} = 2'b10;
      @(posedge clk);
      #1;
   endtask
   task automatic rd(input logic p, input logic [2:0] a,
                     output logic [7:0] d);
      int n;
      {cs_n, pick, addr, rd_n} = {1'b0, p, a, 1'b0};
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (data_oe !== 1'b1 && n < 8);
      d = data_out;
      #1 rd_n = 1'b1;
      @(posedge clk);
      #1 cs_n = 1'b1;
      @(posedge clk);
      #1;
   endtask
endmodule

/* File: host_port_defines.svh */
// Constants for the dual channel host bus port.
// Assumes inclusion by bare name from the package and modules.
`ifndef HOST_PORT_DEFINES_SVH
`define HOST_PORT_DEFINES_SVH
`define HP_ADDR_W        3
`define HP_DATA_W        8
`define HP_AFR_ADDR      3'h2
`define HP_MCR_ADDR      3'h4
`define HP_AFR_BOTH_BIT  0
`define HP_MCR_IR_BIT    6
`define HP_RESET_BYTE    8'h00
`define HP_SEL_CHAN_A    1'b1
`endif

/* File: host_port_pkg.sv */
// Types for the dual channel host bus port.
// Assumes host_port_defines.svh is on the include path.
`include "host_port_defines.svh"
package host_port_pkg;
   typedef struct packed {
      logic                    cs_n;
      logic                    pick;
      logic                    rd_n;
      logic                    wr_n;
      logic [`HP_ADDR_W-1:0]   addr;
      logic [`HP_DATA_W-1:0]   din;
   } bus_in_t;
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b001,
      ST_READ  = 3'b010,
      ST_WRITE = 3'b100
   } cyc_state_t;
endpackage

/* File: tb_top.sv */
// Self-checking testbench for the dual channel host bus port.
// Assumes host_model.sv and the design files are compiled first.
`timescale 1ns/10ps
module tb_top;
   logic                   clk;       // System clock
   logic                   rst;       // Sync reset
   host_port_pkg::bus_in_t bus_in;    // Bus pins
   logic [7:0]             data_out;  // Read byte
   logic                   data_oe;   // Data enable
   logic [1:0]             svc_req;   // Service requests
   logic [1:0]             tx_space;  // Transmit space
   logic [1:0]             tx_data;   // Serial bits
   logic [1:0]             tx_busy;   // Sending flags
   logic                   ia, ib, ra_n, rb_n, sa, sb;
   logic [1:0]             ir_mode;   // Infrared flags
   logic [7:0]             v;         // Read value
   int                     n_errors, compares;
   host_bus_port i_host_bus_port (.clk(clk), .rst(rst), .bus_in(bus_in),
      .data_out(data_out), .data_oe(data_oe), .svc_req(svc_req),
      .tx_space(tx_space), .tx_data(tx_data), .tx_busy(tx_busy),
      .irq_chan_a(ia), .irq_chan_b(ib), .tx_space_avail_a_n(ra_n),
      .tx_space_avail_b_n(rb_n), .serial_out_a(sa), .serial_out_b(sb),
      .ir_mode(ir_mode));
   host_model i_host_model (.clk(clk), .data_out(data_out),
      .data_oe(data_oe), .bus_in(bus_in));
   always #4 clk = ~clk;
   // **************************
   // Checks and closing
   // **************************
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch at %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic results();
      $display("errors %0d compares %0d", n_errors, compares);
      if (n_errors == 0 && compares > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // **************************
   // Scenarios
   // **************************
   task automatic t_reset();
      chk({ia, ib, ra_n, rb_n, sa, sb, ir_mode}, 8'h3c);
      chk({7'h00, data_oe}, 8'h00);
      $display("test reset done");
   endtask
   task automatic t_rw();
      for (int a = 0; a < 8; a++) begin
         if (a == 2 || a == 4)
            continue;
         i_host_model.wr(1'b0, 1'b1, a[2:0], 8'h10 + a[7:0]);
         i_host_model.wr(1'b0, 1'b0, a[2:0], 8'he0 + a[7:0]);
      end
      for (int a = 0; a < 8; a++) begin
         if (a == 2 || a == 4)
            continue;
         i_host_model.rd(1'b1, a[2:0], v);
         chk(v, 8'h10 + a[7:0]);
         i_host_model.rd(1'b0, a[2:0], v);
         chk(v, 8'he0 + a[7:0]);
      end
      $display("test read write done");
   endtask
   task automatic t_ignore();
      i_host_model.wr(1'b1, 1'b1, 3'h3, 8'h77);
      chk({7'h00, data_oe}, 8'h00);
      i_host_model.rd(1'b1, 3'h3, v);
      chk(v, 8'h13);
      $display("test deselect done");
   endtask
   task automatic t_bcast();
      i_host_model.wr(1'b0, 1'b1, 3'h2, 8'h01);
      i_host_model.wr(1'b0, 1'b0, 3'h5, 8'h3c);
      i_host_model.rd(1'b1, 3'h5, v);
      chk(v, 8'h3c);
      i_host_model.wr(1'b0, 1'b1, 3'h2, 8'h00);
      i_host_model.wr(1'b0, 1'b0, 3'h5, 8'h99);
      i_host_model.rd(1'b1, 3'h5, v);
      chk(v, 8'h3c);
      i_host_model.rd(1'b0, 3'h5, v);
      chk(v, 8'h99);
      $display("test broadcast done");
   endtask
   task automatic t_line();
      i_host_model.wr(1'b0, 1'b1, 3'h4, 8'h40);
      cyc(3);
      chk({4'h0, ir_mode, sa, sb}, 8'h09);
      {tx_busy, tx_data} = 4'b1100;
      cyc(3);
      chk({6'h00, sa, sb}, 8'h02);
      {tx_busy, tx_data} = 4'b0000;
      i_host_model.wr(1'b0, 1'b1, 3'h4, 8'h00);
      cyc(3);
      chk({4'h0, ir_mode, sa, sb}, 8'h03);
      $display("test serial line done");
   endtask
   task automatic t_flags();
      {svc_req, tx_space} = 4'b1001;
      cyc(2);
      chk({4'h0, ia, ib, ra_n, rb_n}, 8'h0a);
      {svc_req, tx_space} = 4'b0110;
      cyc(2);
      chk({4'h0, ia, ib, ra_n, rb_n}, 8'h05);
      $display("test flags done");
   endtask
   initial begin
      {clk, rst, n_errors, compares} = {2'b01, 64'h0};
      {svc_req, tx_space, tx_data, tx_busy} = 8'h00;
      cyc(5);
      rst = 1'b0;
      cyc(1);
      t_reset();
      t_rw();
      t_ignore();
      t_bcast();
      t_line();
      t_flags();
      results();
   end
   initial begin
      #100000;
      n_errors++;
      results();
   end
endmodule
